// File: circle_limiter.sv
// Two-dimensional circular limiter for the voltage vector.
`timescale 1ns/10ps
`include "servo_cascade_defines.svh"

// Sequential limiter: scales the vector down when its length exceeds the radius.
module circle_limiter
   import servo_cascade_pkg::*;
(
   // Clock and reset
   input  wire logic            mclk,
   input  wire logic            nrst,
   // Vector in, radius
   input  wire qd_pair_t        vec_in,
   input  wire logic [15:0]     radius,
   // Limited vector
   output qd_pair_t             vec_out
);

   // ****************************************************************
   // Length comparison
   // ****************************************************************
   // Squares are compared so that no square root is needed; the scale is the radius divided by
   // the magnitude sum |q|+|d|, which never underestimates the length, so results land inside.
   wire logic [31:0] sq_q    = 32'($signed(vec_in.quad) * $signed(vec_in.quad));
   wire logic [31:0] sq_d    = 32'($signed(vec_in.direct) * $signed(vec_in.direct));
   wire logic [32:0] len_sq  = {1'b0, sq_q} + {1'b0, sq_d};
   wire logic [32:0] rad_sq  = 33'(radius * radius);
   wire logic        over    = len_sq > rad_sq;
   wire logic [47:0] scale_num = {radius, 32'h00000000};
   wire logic [15:0] abs_q   = vec_in.quad[15] ? 16'(-vec_in.quad) : vec_in.quad;
   wire logic [15:0] abs_d   = vec_in.direct[15] ? 16'(-vec_in.direct) : vec_in.direct;
   wire logic [31:0] len_est = 32'(abs_q + abs_d);
   wire logic [15:0] gain    = (len_est == 32'h00000000) ? 16'h0000 :
                               16'(scale_num / {len_est, 16'h0000} );
   wire logic signed [31:0] q_scaled = $signed(vec_in.quad) * $signed({1'b0, gain[15:1]});
   wire logic signed [31:0] d_scaled = $signed(vec_in.direct) * $signed({1'b0, gain[15:1]});

   // Registered output, scaled when outside the circle.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         vec_out <= '0;
      else if (over)
         vec_out <= {q_scaled[30:15], d_scaled[30:15]};
      else
         vec_out <= vec_in;
   end

endmodule // circle_limiter

// File: servo_cascade_asserts.sv
// Concurrent checks on the ports of the servo cascade limits block.
`timescale 1ns/10ps
`include "servo_cascade_defines.svh"

module servo_cascade_asserts
   import servo_cascade_pkg::*;
(
   // Clock and reset
   input wire logic        mclk,
   input wire logic        nrst,
   // Register bus
   input wire avmm_req_t   avs_req,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // Loop outputs
   input wire qd_pair_t    current_command,
   input wire logic        outer_loop_tick,
   input wire logic        controller_structure,
   input wire logic        integrator_clear,
   input wire logic [7:0]  motion_mode
);
   // ****************************************************************
   // Helpers and properties
   // ****************************************************************
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   logic [7:0] tick_gap;

   // Cycles since the last outer tick; a stuck divider shows as a growing gap.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         tick_gap <= 8'h00;
      else
         tick_gap <= outer_loop_tick ? 8'h00 : tick_gap + 8'h01;
   end

   sequence s_cfg_write;
      avs_req.write && avs_req.address == `IDX_MOTION_LOOP_CONFIG && !avs_waitrequest;
   endsequence
   sequence s_one_wait;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence

   chk_wait_first: assert property ($rose(avs_req.read || avs_req.write) |-> s_one_wait)
      else $error("access did not take exactly one wait state");
   chk_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   chk_read_hold: assert property (!avs_req.read |=> $stable(avs_readdata))
      else $error("read data changed without a read");
   chk_mode_copy: assert property (s_cfg_write |-> ##2
      motion_mode == $past(avs_req.writedata[7:0], 2))
      else $error("motion mode does not follow the written field");
   chk_struct_bit: assert property (s_cfg_write |-> ##2
      controller_structure == $past(avs_req.writedata[31], 2))
      else $error("controller structure does not follow bit 31");
   chk_stop_clear: assert property ((motion_mode == 8'h00 || motion_mode == 8'h09) |-> integrator_clear && current_command == 32'h00000000)
      else $error("stopped mode left outputs or integrators active");
   chk_run_clear: assert property (motion_mode inside {8'h01, 8'h02, 8'h03} |-> !integrator_clear)
      else $error("integrators held cleared in a running mode");
   chk_tick_gap: assert property (tick_gap < 8'h80)
      else $error("outer loop tick missing for more than 128 cycles");
endmodule // servo_cascade_asserts

// File: servo_cascade_defines.svh
// Register offsets, field positions and reset values for the servo cascade limits block.
`ifndef SERVO_CASCADE_DEFINES_SVH
`define SERVO_CASCADE_DEFINES_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_VOLTAGE_VECTOR_RADIUS  8'h5D
`define IDX_CURRENT_TARGET_LIMIT   8'h5E
`define IDX_VELOCITY_ABS_LIMIT     8'h60
`define IDX_POSITION_BARRIER_LOW   8'h61
`define IDX_POSITION_BARRIER_HIGH  8'h62
`define IDX_MOTION_LOOP_CONFIG     8'h63
`define IDX_TORQUE_FLUX_SETPOINT   8'h64
`define IDX_TORQUE_FLUX_FEEDFWD    8'h65
`define IDX_VELOCITY_SETPOINT      8'h66
`define IDX_VELOCITY_FEEDFWD       8'h67
`define IDX_POSITION_SETPOINT      8'h68
`define IDX_MEASURED_TORQUE_FLUX   8'h69
`define IDX_MEASURED_VELOCITY      8'h6A
`define IDX_MEASURED_POSITION      8'h6B

// ****************************************************************
// Field positions
// ****************************************************************
`define MODE_MOTION_MSB            7
`define MODE_DECIM_LSB             24
`define MODE_DECIM_MSB             30
`define MODE_STRUCTURE_BIT         31

// ****************************************************************
// Reset values and answers
// ****************************************************************
`define RESET_WORD                 32'h00000000
`define RESET_HALF                 16'h0000
`define UNMAPPED_READ              32'h00000000
`define RADIUS_MAX                 16'h7FFF
`define VEL_POS_MAX                32'h7FFFFFFF

`endif

// File: servo_cascade_limits.sv
// Register file, limiters and mode control of the cascaded servo loop.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/10ps
`include "servo_cascade_defines.svh"

// Contract
// - Circular limiter bounds the quadrature/direct voltage vector into inverse rotation.
// - Limiter radius is the absolute value of the signed radius field.
// - Torque and flux setpoints clamp to one shared unsigned current limit.
// - Velocity controller input clamps in magnitude to the velocity limit.
// - Position controller input never falls below the lower barrier unless the upper barrier is set below it.
// - Position controller input never rises above the upper barrier.
// - Motion mode field bits 7:0 selects stop, torque, velocity, position and others.
// - Velocity and position loops run decimated by the 7-bit factor.
// - Bit 31 selects parallel or sequential controller structure.
// - Torque mode takes flux low half, torque high half of setpoint register.
// - Signed feed-forward offsets add to flux and torque loop inputs.
// - Velocity mode uses the velocity setpoint register.
// - Velocity feed-forward adds in velocity and position modes.
// - Position mode uses the position setpoint register.
// - Measured flux low half, measured torque high half are reported.
// - Filtered measured velocity is reported.
// - Measured position is reported for the position controller.
// - Inverse transform output length limited to the programmed radius.
// - Position differences accumulate; low half one revolution, high half turns.
// - Writing measured position also loads the position setpoint.
module servo_cascade_limits
   import servo_cascade_pkg::*;
(
   // Clock and reset
   input  wire logic            mclk,
   input  wire logic            nrst,
   // Avalon-MM slave
   input  wire avmm_req_t       avs_req,
   output logic [31:0]          avs_readdata,
   output logic                 avs_waitrequest,
   // Measurements from the front ends
   input  wire qd_pair_t        meas_current,
   input  wire logic [31:0]     meas_velocity_raw,
   input  wire logic [15:0]     meas_angle,
   // External voltage and loop voltage demand
   input  wire qd_pair_t        external_voltage_drive,
   input  wire qd_pair_t        loop_voltage,
   // Controller commands to the PI stages
   output qd_pair_t             current_command,
   output logic [31:0]          velocity_command,
   output logic [31:0]          position_command,
   output logic                 outer_loop_tick,
   output logic                 controller_structure,
   output logic                 integrator_clear,
   output logic [7:0]           motion_mode,
   // Limited voltage vector to the inverse transform
   output qd_pair_t             limited_voltage
);

   // ****************************************************************
   // Register storage
   // ****************************************************************
   logic [15:0] voltage_vector_radius;
   logic [15:0] current_target_limit;
   logic [31:0] velocity_abs_limit;
   logic [31:0] position_barrier_low;
   logic [31:0] position_barrier_high;
   logic [31:0] motion_and_loop_config;
   qd_pair_t    torque_flux_setpoint;
   qd_pair_t    torque_flux_feedforward;
   logic [31:0] velocity_setpoint;
   logic [31:0] velocity_feedforward;
   logic [31:0] position_setpoint;
   qd_pair_t    measured_torque_flux;
   logic [31:0] measured_velocity;
   logic [31:0] measured_position;
   logic [15:0] last_angle;
   logic [6:0]  decim_count;
   logic        access_done;
   loop_state_t loop_state;
   loop_state_t next_loop_state;

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   // One wait state: the first cycle of a request is stalled, the second completes.
   wire logic [7:0] idx       = avs_req.address;
   wire logic       req_any   = avs_req.read | avs_req.write;
   wire logic       req_fire  = req_any & access_done;
   wire logic       wr_fire   = avs_req.write & access_done;
   wire logic       wr_pos_act = wr_fire & (idx == `IDX_MEASURED_POSITION);
   wire logic [31:0] wdata    = avs_req.writedata;

   // Completion flag toggles so each request sees exactly one stalled cycle.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         access_done <= 1'b0;
      else
         access_done <= req_any & ~access_done;
   end

   // Waitrequest from a flop: high except in the completing cycle.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= ~(req_any & ~access_done);
   end

   // ****************************************************************
   // Writable registers
   // ****************************************************************
   // Software-written configuration and setpoints.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         voltage_vector_radius   <= `RESET_HALF;
         current_target_limit    <= `RESET_HALF;
         velocity_abs_limit      <= `RESET_WORD;
         position_barrier_low    <= `RESET_WORD;
         position_barrier_high   <= `RESET_WORD;
         motion_and_loop_config  <= `RESET_WORD;
         torque_flux_setpoint    <= '0;
         torque_flux_feedforward <= '0;
         velocity_setpoint       <= `RESET_WORD;
         velocity_feedforward    <= `RESET_WORD;
      end
      else if (wr_fire)
      begin
         if (idx == `IDX_VOLTAGE_VECTOR_RADIUS) voltage_vector_radius <= wdata[15:0];
         if (idx == `IDX_CURRENT_TARGET_LIMIT) current_target_limit <= wdata[15:0];
         if (idx == `IDX_VELOCITY_ABS_LIMIT) velocity_abs_limit <= wdata;
         if (idx == `IDX_POSITION_BARRIER_LOW) position_barrier_low <= wdata;
         if (idx == `IDX_POSITION_BARRIER_HIGH) position_barrier_high <= wdata;
         if (idx == `IDX_MOTION_LOOP_CONFIG) motion_and_loop_config <= wdata;
         if (idx == `IDX_TORQUE_FLUX_SETPOINT) torque_flux_setpoint <= wdata;
         if (idx == `IDX_TORQUE_FLUX_FEEDFWD) torque_flux_feedforward <= wdata;
         if (idx == `IDX_VELOCITY_SETPOINT) velocity_setpoint <= wdata;
         if (idx == `IDX_VELOCITY_FEEDFWD) velocity_feedforward <= wdata;
      end
   end

   // Position setpoint also follows a write of the measured position.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         position_setpoint <= `RESET_WORD;
      else if (wr_pos_act | (wr_fire & (idx == `IDX_POSITION_SETPOINT)))
         position_setpoint <= wdata;
   end

   // ****************************************************************
   // Measurements
   // ****************************************************************
   // Signed wrap of the 16-bit angle difference gives the step across a revolution.
   wire logic [15:0] angle_step = meas_angle - last_angle;
   wire logic [31:0] step_ext   = {{16{angle_step[15]}}, angle_step};

   // Measured current is latched and measured velocity averaged with the raw input each cycle.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         measured_torque_flux <= '0;
         measured_velocity    <= `RESET_WORD;
      end
      else
      begin
         measured_torque_flux <= meas_current;
         measured_velocity <= 32'((33'($signed(measured_velocity)) +
                                   33'($signed(meas_velocity_raw))) >>> 1);
      end
   end

   // Multi-turn accumulator; a software write overrides the accumulation.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         measured_position <= `RESET_WORD;
         last_angle        <= `RESET_HALF;
      end
      else
      begin
         last_angle <= meas_angle;
         if (wr_pos_act)
            measured_position <= wdata;
         else
            measured_position <= measured_position + step_ext;
      end
   end

   // ****************************************************************
   // Mode decode
   // ****************************************************************
   // motion mode decode
   wire logic [7:0] mode_field = motion_and_loop_config[`MODE_MOTION_MSB:0];
   always_comb
   begin
      unique case (mode_field)
         8'h01, 8'h04, 8'h05, 8'h0A, 8'h0D: next_loop_state = ST_TORQUE;
         8'h02, 8'h06, 8'h0B, 8'h0E:        next_loop_state = ST_VELOCITY;
         8'h03, 8'h07, 8'h0C, 8'h0F:        next_loop_state = ST_POSITION;
         8'h08:                             next_loop_state = ST_VOLTAGE;
         default:                           next_loop_state = ST_STOP;
      endcase
   end

   // Loop state register.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         loop_state <= ST_STOP;
      else
         loop_state <= next_loop_state;
   end

   // ****************************************************************
   // Limiters
   // ****************************************************************
   // absolute radius
   wire logic [15:0] radius_abs = voltage_vector_radius[15] ?
                                  16'(-voltage_vector_radius) : voltage_vector_radius;
   wire logic [15:0] radius_eff = (radius_abs > `RADIUS_MAX) ? `RADIUS_MAX : radius_abs;

   // Symmetric clamp of a 16-bit signed value to an unsigned limit.
   function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lim);
      logic signed [16:0] sv;
      logic signed [16:0] sl;
      sv = {v[15], v};
      sl = {1'b0, lim};
      if (sv > sl)
         clamp16 = lim[15:0];
      else if (sv < -sl)
         clamp16 = 16'(-sl);
      else
         clamp16 = v;
   endfunction

   wire logic [15:0] flux_sp   = clamp16(torque_flux_setpoint.direct, current_target_limit);
   wire logic [15:0] torque_sp = clamp16(torque_flux_setpoint.quad, current_target_limit);
   wire logic [15:0] flux_in   = flux_sp + torque_flux_feedforward.direct;
   wire logic [15:0] torque_in = torque_sp + torque_flux_feedforward.quad;

   wire logic [31:0] pos_low_cl = ($signed(position_setpoint) < $signed(position_barrier_low)) ?
                                  position_barrier_low : position_setpoint;
   wire logic [31:0] pos_cl     = ($signed(pos_low_cl) > $signed(position_barrier_high)) ?
                                  position_barrier_high : pos_low_cl;

   wire logic [31:0] vel_lim   = (velocity_abs_limit > `VEL_POS_MAX) ? `VEL_POS_MAX :
                                 velocity_abs_limit;
   wire logic [31:0] vel_cl    = ($signed(velocity_setpoint) > $signed(vel_lim)) ? vel_lim :
                                 ($signed(velocity_setpoint) < -$signed(vel_lim)) ?
                                 32'(-vel_lim) : velocity_setpoint;
   wire logic [31:0] vel_in    = vel_cl + velocity_feedforward;

   // ****************************************************************
   // Outer loop timing and structure
   // ****************************************************************
   // decimation counter
   wire logic [6:0] decim_factor = motion_and_loop_config[`MODE_DECIM_MSB:`MODE_DECIM_LSB];
   wire logic       decim_hit    = (decim_count >= decim_factor);

   // Tick every factor+1 cycles; zero factor runs the outer loops every cycle.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         decim_count     <= 7'h00;
         outer_loop_tick <= 1'b0;
      end
      else
      begin
         decim_count     <= decim_hit ? 7'h00 : 7'(decim_count + 7'h01);
         outer_loop_tick <= decim_hit;
      end
   end

   // ****************************************************************
   // Controller commands
   // ****************************************************************
   // Outer-loop commands change only on outer ticks, or clear at once in stop, as the PI stages expect.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         current_command      <= '0;
         velocity_command     <= `RESET_WORD;
         position_command     <= `RESET_WORD;
         controller_structure <= 1'b0;
         integrator_clear     <= 1'b1;
         motion_mode          <= 8'h00;
      end
      else
      begin
         controller_structure <= motion_and_loop_config[`MODE_STRUCTURE_BIT];
         motion_mode          <= mode_field;
         integrator_clear     <= (next_loop_state == ST_STOP);
         unique case (next_loop_state)
            ST_TORQUE:   current_command <= {torque_in, flux_in};
            ST_VELOCITY, ST_POSITION: current_command <= torque_flux_feedforward;
            ST_VOLTAGE, ST_STOP:      current_command <= '0;
         endcase
         if (next_loop_state == ST_STOP)
         begin
            velocity_command <= `RESET_WORD;
            position_command <= `RESET_WORD;
         end
         else if (decim_hit)
         begin
            position_command <= (next_loop_state == ST_POSITION) ? pos_cl : measured_position;
            velocity_command <= (next_loop_state == ST_VELOCITY) ? vel_in : velocity_feedforward;
         end
      end
   end

   // ****************************************************************
   // Voltage vector limiting
   // ****************************************************************
   wire qd_pair_t volt_pre = (loop_state == ST_VOLTAGE) ? external_voltage_drive :
                             (loop_state == ST_STOP) ? qd_pair_t'(32'h00000000) : loop_voltage;

   circle_limiter u_limiter (
      .mclk    (mclk),
      .nrst    (nrst),
      .vec_in  (volt_pre),
      .radius  (radius_eff),
      .vec_out (limited_voltage)
   );

   // ****************************************************************
   // Read path
   // ****************************************************************
   wire logic [31:0] rd_mux =
      (idx == `IDX_VOLTAGE_VECTOR_RADIUS) ? {16'h0000, voltage_vector_radius} :
      (idx == `IDX_CURRENT_TARGET_LIMIT)  ? {16'h0000, current_target_limit} :
      (idx == `IDX_VELOCITY_ABS_LIMIT)    ? velocity_abs_limit :
      (idx == `IDX_POSITION_BARRIER_LOW)  ? position_barrier_low :
      (idx == `IDX_POSITION_BARRIER_HIGH) ? position_barrier_high :
      (idx == `IDX_MOTION_LOOP_CONFIG)    ? motion_and_loop_config :
      (idx == `IDX_TORQUE_FLUX_SETPOINT)  ? torque_flux_setpoint :
      (idx == `IDX_TORQUE_FLUX_FEEDFWD)   ? torque_flux_feedforward :
      (idx == `IDX_VELOCITY_SETPOINT)     ? velocity_setpoint :
      (idx == `IDX_VELOCITY_FEEDFWD)      ? velocity_feedforward :
      (idx == `IDX_POSITION_SETPOINT)     ? position_setpoint :
      (idx == `IDX_MEASURED_TORQUE_FLUX)  ? measured_torque_flux :
      (idx == `IDX_MEASURED_VELOCITY)     ? measured_velocity :
      (idx == `IDX_MEASURED_POSITION)     ? measured_position : `UNMAPPED_READ;

   // Read data registered in the stalled cycle so it stands at the completing edge.
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         avs_readdata <= `UNMAPPED_READ;
      else if (avs_req.read & ~access_done)
         avs_readdata <= rd_mux;
   end

endmodule // servo_cascade_limits

// File: servo_cascade_pkg.sv
// Types shared by the servo cascade limits block.
package servo_cascade_pkg;

   // Packed quadrature/direct pair, direct in the low half.
   typedef struct packed {
      logic signed [15:0] quad;
      logic signed [15:0] direct;
   } qd_pair_t;

   // Avalon-MM request from the master.
   typedef struct packed {
      logic [7:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
   } avmm_req_t;

   // Motion modes with one-hot codes.
   typedef enum logic [4:0] {
      ST_STOP     = 5'b00001,
      ST_TORQUE   = 5'b00010,
      ST_VELOCITY = 5'b00100,
      ST_POSITION = 5'b01000,
      ST_VOLTAGE  = 5'b10000
   } loop_state_t;

endpackage

// File: testbench.sv
// Self-checking bench for the servo cascade limits block.
`timescale 1ns/10ps
`include "servo_cascade_defines.svh"

module testbench
   import servo_cascade_pkg::*;
;
   typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
   logic        mclk, nrst, wait_rq, tick, cstruct, iclr;
   avmm_req_t   req;
   qd_pair_t    meas_i, ext_v, loop_v, cur_cmd, lim_v;
   logic [31:0] rdata, vel_raw, vel_cmd, pos_cmd, q;
   logic [15:0] angle;
   logic [7:0]  mode;
   int          miscompares, checks_done, vq, vd, gap;
   row_t        rows [13] = '{'{8'h5D, 32'h00018005, 32'h00008005},
      '{8'h5E, 32'hFFFF1234, 32'h00001234}, '{8'h60, 32'h80000001, 32'h80000001},
      '{8'h61, 32'h87654321, 32'h87654321}, '{8'h62, 32'h12345678, 32'h12345678},
      '{8'h64, 32'hDEADBEEF, 32'hDEADBEEF}, '{8'h65, 32'h01020304, 32'h01020304},
      '{8'h66, 32'hFFFFFF00, 32'hFFFFFF00}, '{8'h67, 32'h00000011, 32'h00000011},
      '{8'h68, 32'h7FFFFFFF, 32'h7FFFFFFF}, '{8'h69, 32'h11111111, 32'h0ABC0123},
      '{8'h6A, 32'h00000000, 32'h000000FF}, '{8'h7F, 32'hFFFFFFFF, 32'h00000000}};

   servo_cascade_limits dut (.mclk(mclk), .nrst(nrst), .avs_req(req), .avs_readdata(rdata),
      .avs_waitrequest(wait_rq), .meas_current(meas_i), .meas_velocity_raw(vel_raw),
      .meas_angle(angle), .external_voltage_drive(ext_v), .loop_voltage(loop_v),
      .current_command(cur_cmd), .velocity_command(vel_cmd), .position_command(pos_cmd),
      .outer_loop_tick(tick), .controller_structure(cstruct), .integrator_clear(iclr),
      .motion_mode(mode), .limited_voltage(lim_v));

   // ****************************************************************
   // Compare, bus and closing tasks
   // ****************************************************************
   task automatic cmp_word(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         miscompares++;
      end
   endtask
   task automatic cmp_bit(input string n, input logic e, input logic g);
      cmp_word(n, {31'h0, e}, {31'h0, g});
   endtask
   // One Avalon access; the request holds until waitrequest is sampled low.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      req <= '{address: a, read: !w, write: w, writedata: d};
      do @(posedge mclk); while (wait_rq !== 1'b0);
      q = rdata;
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Free-running 250 MHz clock.
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // Watchdog, far beyond the few hundred cycles the sequence needs.
   initial
   begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      final_report;
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      nrst = 1'b0; req = '0; meas_i = 32'h0ABC0123; vel_raw = 32'h100; angle = 16'h1234;
      ext_v = 32'h7FFF7FFF; loop_v = 32'h0;
      repeat (10) @(posedge mclk);
      cmp_bit("reset wait", 1'b1, wait_rq);
      cmp_bit("reset clear", 1'b1, iclr);
      nrst <= 1'b1;
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d);
         bus(1'b0, rows[i].a, 32'h0);
         cmp_word("readback", rows[i].e, q);
      end
      // Writing the measured position also moves the setpoint.
      wr(8'h6B, 32'h00012345);
      bus(1'b0, 8'h68, 32'h0);
      cmp_word("setpoint copy", 32'h00012345, q);
      angle <= 16'hF234;
      bus(1'b0, 8'h6B, 32'h0);
      cmp_word("position", 32'h00010345, q);
      wr(8'h5E, 32'h100); wr(8'h64, 32'h0500FE00); wr(8'h65, 32'h0); wr(8'h63, 32'h1);
      repeat (4) @(posedge mclk);
      cmp_word("current clamp", 32'h0100FF00, cur_cmd);
      wr(8'h65, 32'h0010FFF0); repeat (4) @(posedge mclk);
      cmp_word("current offset", 32'h0110FEF0, cur_cmd);
      wr(8'h60, 32'h3E8); wr(8'h66, 32'h1388); wr(8'h67, 32'h0); wr(8'h63, 32'h2);
      repeat (4) @(posedge mclk);
      cmp_word("velocity clamp", 32'h3E8, vel_cmd);
      wr(8'h66, 32'hFFFFEC78); repeat (4) @(posedge mclk);
      cmp_word("velocity clamp low", 32'hFFFFFC18, vel_cmd);
      wr(8'h66, 32'h64); wr(8'h67, 32'h14); repeat (4) @(posedge mclk);
      cmp_word("velocity offset", 32'h78, vel_cmd);
      wr(8'h61, 32'hFFFFFFCE); wr(8'h62, 32'hC8); wr(8'h68, 32'h384); wr(8'h63, 32'h3);
      repeat (4) @(posedge mclk);
      cmp_word("upper barrier", 32'hC8, pos_cmd);
      wr(8'h68, 32'hFFFFFC7C); repeat (4) @(posedge mclk);
      cmp_word("lower barrier", 32'hFFFFFFCE, pos_cmd);
      wr(8'h68, 32'h4D); repeat (4) @(posedge mclk);
      cmp_word("position target", 32'h4D, pos_cmd);
      wr(8'h63, 32'h83000003);
      do @(posedge mclk); while (tick !== 1'b1);
      gap = 0;
      do begin @(posedge mclk); gap++; end while (tick !== 1'b1 && gap < 300);
      cmp_word("tick period", 32'h4, gap);
      cmp_bit("structure", 1'b1, cstruct);
      wr(8'h5D, 32'hFFF0); wr(8'h63, 32'h8); repeat (5) @(posedge mclk);
      vq = lim_v.quad;
      vd = lim_v.direct;
      cmp_bit("vector length", 1'b1, vq * vq + vd * vd <= 256);
      ext_v <= 32'h00030004; wr(8'h5D, 32'h64); repeat (5) @(posedge mclk);
      cmp_word("vector inside", 32'h00030004, lim_v);
      wr(8'h63, 32'h9); repeat (4) @(posedge mclk);
      cmp_bit("reserved clear", 1'b1, iclr);
      cmp_word("reserved zero", 32'h0, cur_cmd);
      final_report;
   end
endmodule // testbench

bind servo_cascade_limits servo_cascade_asserts chk (.mclk(mclk), .nrst(nrst),
   .avs_req(avs_req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .current_command(current_command), .outer_loop_tick(outer_loop_tick),
   .controller_structure(controller_structure), .integrator_clear(integrator_clear),
   .motion_mode(motion_mode));
